//--- shared/fpe_defs.svh
// Functional notes
// - Page buffer holds 64 bytes, each with its own update flag.
// - Command 00H clears every page buffer byte and every update flag.
// - Data port write stores the byte at the low 6 address bits.
// - Data port write sets the update flag of the written location.
// - Low 6 address bits increment after each data write, wrapping; bits 7:6 kept.
// - Target page is the high address byte plus low address bits 7:6.
// - Only flagged bytes of the selected page are erased and reprogrammed.
// - Command 68H starts the erase-program cycle and stalls the processor.
// - Stall lasts until completion, interrupt or brown-out; status then holds the cycle result.
// - An interrupt during the cycle aborts it and sets the interrupted flag.
// - The cycle lasts 4 ms: 2 ms erase then 2 ms program.
// - Command register reads status; any command write clears all status bits.
// - Code memory pages are 64 bytes, matching the page buffer.
// - Erase-program only runs in unsecured sectors; code reads stay untouched.
// - Status bit 0 flags a cycle aborted by interrupt; brown-out abort and reset leave it clear.
// - Status bit 1 flags a security violation on a secured sector.
// - Bit 3 flags high-voltage abort; bit 2 flags high-voltage generator error.
`ifndef FPE_DEFS_SVH
`define FPE_DEFS_SVH

`define FPE_CMD_LOAD      8'h00
`define FPE_CMD_EP        8'h68
`define FPE_PAGE_BYTES    64
`define FPE_IDX_W         6
`define FPE_PAGE_W        10
`define FPE_OP_INTERRUPTED_BIT      0
`define FPE_SECURITY_VIOLATION_BIT  1
`define FPE_HV_ERROR_BIT            2
`define FPE_HV_ABORT_BIT            3
`define FPE_STATUS_RST    8'h00
`define FPE_ADDR_RST      8'h00
`define FPE_CLK_HZ        20000000
`define FPE_ERASE_TIME_MS 2
`define FPE_PROG_TIME_MS  2
`define FPE_ERASE_CYC     (`FPE_ERASE_TIME_MS * `FPE_CLK_HZ / 1000)
`define FPE_PROG_CYC      (`FPE_PROG_TIME_MS * `FPE_CLK_HZ / 1000)
`define FPE_SECT_SHIFT    4
`define FPE_N_SECTORS     64

`endif

//--- shared/fpe_pkg.sv
package fpe_pkg;
    // Write strobes from the core for the four special-function registers
    typedef struct packed {
        logic       cmd_we;
        logic       addr_lo_we;
        logic       addr_hi_we;
        logic       data_we;
        logic [7:0] wdata;
    } fpe_sfr_wr_t;

    // Status view of the command register
    typedef struct packed {
        logic [3:0] rsvd;
        logic       high_voltage_abort_flag;
        logic       high_voltage_error_flag;
        logic       security_violation_flag;
        logic       op_interrupted_flag;
    } fpe_status_t;

    typedef enum logic [2:0] {
        FPE_IDLE  = 3'b001,
        FPE_ERASE = 3'b010,
        FPE_PROG  = 3'b100
    } fpe_state_t;
endpackage

//--- src/fpe_phase_timer.sv
`include "fpe_defs.svh"

module fpe_phase_timer
    import fpe_pkg::*;
#(
    parameter int ERASE_CYC = `FPE_ERASE_CYC,
    parameter int PROG_CYC  = `FPE_PROG_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       start,
    input  wire logic       abort,
    output fpe_state_t      phase,
    output logic            done
);
    localparam int CNT_W = $clog2(ERASE_CYC + PROG_CYC) + 1;

    fpe_state_t       state_reg;
    logic [CNT_W-1:0] cnt_reg;

    // Fixed length regardless of how many bytes are flagged
    assign done  = (state_reg == FPE_PROG) && (cnt_reg == CNT_W'(ERASE_CYC + PROG_CYC - 1));
    assign phase = state_reg;

    // Phase sequencing: erase first, then program
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= FPE_IDLE;
        end else begin
            case (state_reg)
                FPE_IDLE: begin
                    if (start) begin
                        state_reg <= FPE_ERASE;
                    end
                end
                FPE_ERASE: begin
                    if (abort) begin
                        state_reg <= FPE_IDLE;
                    end else if (cnt_reg == CNT_W'(ERASE_CYC - 1)) begin
                        state_reg <= FPE_PROG;
                    end
                end
                FPE_PROG: begin
                    if (abort || done) begin
                        state_reg <= FPE_IDLE;
                    end
                end
                default: state_reg <= FPE_IDLE;
            endcase
        end
    end

    // Cycle counter runs across both phases
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
        end else if (state_reg == FPE_IDLE) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end
endmodule

//--- src/fpe_engine.sv
`include "fpe_defs.svh"

module fpe_engine
    import fpe_pkg::*;
#(
    parameter int ERASE_CYC = `FPE_ERASE_CYC,
    parameter int PROG_CYC  = `FPE_PROG_CYC
) (
    input  wire logic                          sys_clk,
    input  wire logic                          arst_n,
    input  fpe_sfr_wr_t                        sfr_wr,
    input  wire logic                          irq_req,
    input  wire logic                          brownout,
    input  wire logic                          bod_enabled,
    input  wire logic                          hv_fault,
    input  wire logic [`FPE_N_SECTORS-1:0]     sector_secured,
    output logic [7:0]                         flash_cmd_status_reg,
    output logic [7:0]                         flash_addr_low_reg,
    output logic [7:0]                         flash_addr_high_reg,
    output logic                               cpu_stall,
    output logic                               hv_erase,
    output logic                               hv_program,
    output logic [`FPE_PAGE_W-1:0]             fl_page,
    output logic [`FPE_PAGE_BYTES-1:0]         fl_byte_mask,
    output logic [`FPE_PAGE_BYTES-1:0][7:0]    fl_page_data
);
    localparam int TOTAL_CYC = ERASE_CYC + PROG_CYC;
    localparam int BC_W      = $clog2(TOTAL_CYC) + 1;

    // Page buffer and its update flags, flip-flop storage
    logic [`FPE_PAGE_BYTES-1:0][7:0] page_buf_reg;
    logic [`FPE_PAGE_BYTES-1:0]      upd_flag_reg;
    fpe_status_t                     status_reg;
    logic [`FPE_PAGE_W-1:0]          page_lat_reg;
    fpe_state_t                      phase;
    logic                            cyc_done;
    logic                            busy;
    logic                            abort_now;
    logic                            cmd_ok;
    logic                            is_load;
    logic                            is_ep;
    logic                            page_secured;
    logic                            ep_start;
    logic [`FPE_IDX_W-1:0]           wr_idx;
    logic [`FPE_PAGE_W-1:0]          page_now;
    logic [BC_W-1:0]                 busy_cnt;

    // Sector lookup of a page; used for the start check and by assertions
    function automatic logic sector_locked(input logic [`FPE_PAGE_W-1:0] pg,
                                           input logic [`FPE_N_SECTORS-1:0] map);
        logic [`FPE_PAGE_W-1:0] sect;
        sect = pg >> `FPE_SECT_SHIFT;
        return map[sect[$clog2(`FPE_N_SECTORS)-1:0]];
    endfunction

    // Command decode; the core is stalled while busy, so writes then are dropped
    assign busy         = (phase != FPE_IDLE);
    assign cmd_ok       = sfr_wr.cmd_we && !busy;
    assign is_load      = cmd_ok && (sfr_wr.wdata == `FPE_CMD_LOAD);
    assign is_ep        = cmd_ok && (sfr_wr.wdata == `FPE_CMD_EP);
    assign page_now     = {flash_addr_high_reg, flash_addr_low_reg[7:6]};
    assign page_secured = sector_locked(page_now, sector_secured);
    assign ep_start     = is_ep && !page_secured && bod_enabled;
    assign abort_now    = busy && (irq_req || brownout);
    assign wr_idx       = flash_addr_low_reg[`FPE_IDX_W-1:0];

    fpe_phase_timer #(
        .ERASE_CYC (ERASE_CYC),
        .PROG_CYC  (PROG_CYC)
    ) u_timer (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .start     (ep_start),
        .abort     (abort_now),
        .phase     (phase),
        .done      (cyc_done)
    );

    // Stall is a handshake level toward the core
    assign cpu_stall    = busy;
    assign hv_erase     = (phase == FPE_ERASE);
    assign hv_program   = (phase == FPE_PROG);
    assign fl_page      = page_lat_reg;
    // Array only touches bytes whose flags are set
    assign fl_byte_mask = upd_flag_reg;
    assign fl_page_data = page_buf_reg;
    assign flash_cmd_status_reg = status_reg;

    // Low address: firmware load or auto-increment that keeps bits 7:6
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            flash_addr_low_reg <= `FPE_ADDR_RST;
        end else if (sfr_wr.addr_lo_we && !busy) begin
            flash_addr_low_reg <= sfr_wr.wdata;
        end else if (sfr_wr.data_we && !busy) begin
            flash_addr_low_reg <= {flash_addr_low_reg[7:6], wr_idx + 6'h01};
        end
    end

    // High address keeps its value across cycles
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            flash_addr_high_reg <= `FPE_ADDR_RST;
        end else if (sfr_wr.addr_hi_we && !busy) begin
            flash_addr_high_reg <= sfr_wr.wdata;
        end
    end

    // Page sampled at the start so later address writes cannot move the cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            page_lat_reg <= '0;
        end else if (ep_start) begin
            page_lat_reg <= page_now;
        end
    end

    // Buffer bytes and flags; reloading a location just overwrites it
    genvar gi;
    generate
        for (gi = 0; gi < `FPE_PAGE_BYTES; gi++) begin : g_byte
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    page_buf_reg[gi] <= 8'h00;
                    upd_flag_reg[gi] <= 1'b0;
                end else if (is_load) begin
                    page_buf_reg[gi] <= 8'h00;
                    upd_flag_reg[gi] <= 1'b0;
                end else if (sfr_wr.data_we && !busy && wr_idx == `FPE_IDX_W'(gi)) begin
                    page_buf_reg[gi] <= sfr_wr.wdata;
                    upd_flag_reg[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    // Status: cleared by any command, set by this cycle's events
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_reg <= `FPE_STATUS_RST;
        end else if (cmd_ok) begin
            status_reg                         <= `FPE_STATUS_RST;
            status_reg.security_violation_flag <= is_ep && page_secured;
            status_reg.high_voltage_abort_flag <= is_ep && !page_secured && !bod_enabled;
        end else if (busy) begin
            if (abort_now) begin
                // Flag was cleared at the start and the abort ends the cycle
                status_reg.op_interrupted_flag     <= irq_req;
                status_reg.high_voltage_abort_flag <= 1'b1;
            end
            if (hv_fault) begin
                status_reg.high_voltage_error_flag <= 1'b1;
            end
        end
    end

    // Helper count of stalled cycles, read only by assertions
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_cnt <= '0;
        end else if (busy) begin
            busy_cnt <= busy_cnt + BC_W'(1);
        end else begin
            busy_cnt <= '0;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // Loading: buffer, flags and address pointer
    load_clears_a: assert property (is_load |=> upd_flag_reg == '0 && page_buf_reg == '0)
        else $error("load command left buffer or flags set");
    data_store_a: assert property (sfr_wr.data_we && !busy |=>
        page_buf_reg[$past(wr_idx)] == $past(sfr_wr.wdata) && upd_flag_reg[$past(wr_idx)])
        else $error("data write not stored with its flag");
    addr_wrap_a: assert property (sfr_wr.data_we && !sfr_wr.addr_lo_we && !busy |=>
        wr_idx == $past(wr_idx) + 6'h01 && $stable(flash_addr_low_reg[7:6]))
        else $error("low address did not advance correctly");

    // Cycle start, stall, the ways a cycle ends early and generator errors
    ep_stall_a: assert property (ep_start |=> cpu_stall && hv_erase)
        else $error("erase-program command did not stall");
    stall_hold_a: assert property (cpu_stall && !abort_now && !cyc_done |=> cpu_stall)
        else $error("stall released early");
    irq_abort_a: assert property (cpu_stall && irq_req |=> !cpu_stall &&
        status_reg.op_interrupted_flag && status_reg.high_voltage_abort_flag)
        else $error("interrupt did not abort the cycle");
    brown_abort_a: assert property (cpu_stall && brownout && !irq_req |=> !cpu_stall &&
        !status_reg.op_interrupted_flag && status_reg.high_voltage_abort_flag)
        else $error("brown-out did not abort the cycle");
    hv_error_a: assert property (busy && hv_fault |=>
        status_reg.high_voltage_error_flag)
        else $error("generator error not flagged");
    bod_refuse_a: assert property (is_ep && !page_secured && !bod_enabled |=>
        !cpu_stall && status_reg.high_voltage_abort_flag)
        else $error("disabled detector did not refuse the cycle");

    // Cycle timing is fixed, whatever the number of flagged bytes
    cycle_len_a: assert property (cyc_done |-> busy_cnt == BC_W'(TOTAL_CYC - 1))
        else $error("cycle length wrong");
    erase_first_a: assert property ($rose(hv_program) |-> $past(hv_erase) &&
        busy_cnt == BC_W'(ERASE_CYC))
        else $error("program phase not after full erase");
    busy_bound_a: assert property (busy |-> busy_cnt < BC_W'(TOTAL_CYC))
        else $error("stall outlasted the cycle");

    // Status clearing, security refusal and the page a cycle works on
    cmd_clear_a: assert property (cmd_ok && !is_ep |=> status_reg == `FPE_STATUS_RST)
        else $error("command write did not clear status");
    secure_block_a: assert property (is_ep && page_secured |=>
        !cpu_stall && status_reg.security_violation_flag)
        else $error("secured page was not refused");
    page_sel_a: assert property (ep_start |=> fl_page == $past(page_now) &&
        !sector_locked(fl_page, $past(sector_secured)))
        else $error("cycle started on a wrong or secured page");
    page_hold_a: assert property (cpu_stall |=> $stable(page_lat_reg))
        else $error("page address moved during cycle");

    // Held state: buffer kept through a cycle, upper status bits always zero
    buf_keep_a: assert property (busy |=>
        $stable(upd_flag_reg) && $stable(page_buf_reg))
        else $error("buffer changed during a cycle");
    rsvd_zero_a: assert property (flash_cmd_status_reg[7:4] == 4'h0)
        else $error("reserved status bits set");
endmodule

//--- tb/fpe_core_model.sv
module fpe_core_model
    import fpe_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  cpu_stall,
    output fpe_sfr_wr_t sfr_wr
);
    timeunit 1ns;
    timeprecision 1ns;

    initial sfr_wr = '0;

    // One store per call: sel 0 command, 1 low address, 2 high address, 3 data port.
    // A stalled core executes nothing, so no store is issued while stalled
    // Callers keep each buffer index once per load and one page per operation
    task automatic do_wr(input logic [1:0] sel, input logic [7:0] d);
        while (cpu_stall === 1'b1) @(negedge sys_clk);
        @(negedge sys_clk);
        sfr_wr = {sel == 2'h0, sel == 2'h1, sel == 2'h2, sel == 2'h3, d};
        @(negedge sys_clk);
        sfr_wr = '0;
    endtask
endmodule

//--- tb/tb_top.sv
`include "fpe_defs.svh"

`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (b)); end end

module tb_top
    import fpe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic                                sys_clk = 1'b0;
    logic                                arst_n, irq_req, brownout, bod_enabled, hv_fault;
    logic [`FPE_N_SECTORS-1:0]           sector_secured;
    fpe_sfr_wr_t                         sfr_wr;
    logic [7:0]                          st, lo, hi;
    logic                                cpu_stall, hv_erase, hv_program;
    logic [`FPE_PAGE_W-1:0]              fl_page;
    logic [`FPE_PAGE_BYTES-1:0]          fl_byte_mask;
    logic [`FPE_PAGE_BYTES-1:0][7:0]     fl_page_data;
    int                                  error_cnt = 0;
    int                                  num_checks = 0;
    int                                  ne, np;

    typedef struct packed { logic [7:0] lo; logic [7:0] d; logic [7:0] nxt; } fpe_row_t;
    // Distinct indices only; the wrap at the page end must keep bits 7:6
    fpe_row_t rows [4] = '{'{8'hC5, 8'hAB, 8'hC6}, '{8'hFF, 8'h11, 8'hC0},
                           '{8'hBE, 8'h22, 8'hBF}, '{8'h41, 8'h33, 8'h42}};

    // Short phases keep the whole run to about a hundred cycles
    fpe_engine #(.ERASE_CYC(4), .PROG_CYC(4)) i_dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .sfr_wr(sfr_wr), .irq_req(irq_req),
        .brownout(brownout), .bod_enabled(bod_enabled), .hv_fault(hv_fault),
        .sector_secured(sector_secured), .flash_cmd_status_reg(st),
        .flash_addr_low_reg(lo), .flash_addr_high_reg(hi), .cpu_stall(cpu_stall),
        .hv_erase(hv_erase), .hv_program(hv_program), .fl_page(fl_page),
        .fl_byte_mask(fl_byte_mask), .fl_page_data(fl_page_data));

    fpe_core_model i_core (.sys_clk(sys_clk), .cpu_stall(cpu_stall), .sfr_wr(sfr_wr));

    always #25 sys_clk = ~sys_clk;

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Start a cycle and count erase and program phase cycles while stalled
    task automatic run_ep();
        ne = 0;
        np = 0;
        i_core.do_wr(2'h0, `FPE_CMD_EP);
        for (int i = 0; i < 40; i++) begin
            if (cpu_stall !== 1'b1) break;
            if (hv_erase === 1'b1) ne++;
            if (hv_program === 1'b1) np++;
            @(negedge sys_clk);
        end
    endtask

    // Hang guard, far beyond the expected run length
    initial begin
        #(3000 * 50);
        error_cnt++;
        end_sim();
    end

    initial begin
        arst_n = 1'b0; irq_req = 1'b0; brownout = 1'b0; bod_enabled = 1'b1; hv_fault = 1'b0;
        sector_secured = 64'h0000000000400000;
        repeat (8) @(negedge sys_clk);
        arst_n = 1'b1;
        `CHK(st, 8'h00)
        `CHK({lo, hi, cpu_stall, fl_byte_mask}, '0)
        i_core.do_wr(2'h0, `FPE_CMD_LOAD);
        // Table: address, data, expected low address after the store
        foreach (rows[k]) begin
            i_core.do_wr(2'h1, rows[k].lo);
            i_core.do_wr(2'h3, rows[k].d);
            `CHK(fl_page_data[rows[k].lo[5:0]], rows[k].d)
            `CHK(fl_byte_mask[rows[k].lo[5:0]], 1'b1)
            `CHK(lo, rows[k].nxt)
        end
        i_core.do_wr(2'h0, `FPE_CMD_LOAD);
        `CHK({fl_byte_mask, fl_page_data}, '0)
        // Cycle on page {12h, 11b} with one flagged byte and a generator fault
        i_core.do_wr(2'h2, 8'h12);
        i_core.do_wr(2'h1, 8'hC7);
        i_core.do_wr(2'h3, 8'h5A);
        hv_fault = 1'b1;
        run_ep();
        hv_fault = 1'b0;
        `CHK(ne, 4)
        `CHK(np, 4)
        `CHK(fl_page, 10'h04B)
        `CHK(fl_byte_mask, 64'h0000000000000080)
        `CHK(st, 8'h04)
        `CHK({fl_page_data[7], lo, hi}, 24'h5AC812)
        run_ep();
        `CHK(st, 8'h00)
        // Interrupt aborts with both flags, brown-out with the abort flag only
        for (int c = 0; c < 2; c++) begin
            i_core.do_wr(2'h0, `FPE_CMD_EP);
            @(negedge sys_clk);
            irq_req = (c == 0);
            brownout = (c == 1);
            repeat (2) @(negedge sys_clk);
            `CHK(cpu_stall, 1'b0)
            `CHK(st, (c == 0) ? 8'h09 : 8'h08)
            irq_req = 1'b0;
            brownout = 1'b0;
            // Firmware sees the interrupted flag and starts over from a fresh load
            if (st[`FPE_OP_INTERRUPTED_BIT] === 1'b1) begin
                i_core.do_wr(2'h0, `FPE_CMD_LOAD);
                i_core.do_wr(2'h1, 8'hC7);
                i_core.do_wr(2'h3, 8'h5A);
                run_ep();
                `CHK({np, fl_byte_mask, st}, {32'd4, 64'h0000000000000080, 8'h00})
            end
        end
        // Secured sector refused without stalling
        i_core.do_wr(2'h2, 8'h5A);
        i_core.do_wr(2'h1, 8'h80);
        i_core.do_wr(2'h0, `FPE_CMD_EP);
        `CHK({cpu_stall, st}, 9'h002)
        // Detector off at start refuses the cycle
        i_core.do_wr(2'h2, 8'h12);
        bod_enabled = 1'b0;
        i_core.do_wr(2'h0, `FPE_CMD_EP);
        bod_enabled = 1'b1;
        `CHK({cpu_stall, st}, 9'h008)
        i_core.do_wr(2'h0, 8'h5A);
        `CHK(st, 8'h00)
        // Reset in mid-cycle drops the stall and leaves clean status
        i_core.do_wr(2'h0, `FPE_CMD_EP);
        @(negedge sys_clk);
        arst_n = 1'b0;
        @(negedge sys_clk);
        `CHK({cpu_stall, hv_erase, st}, 10'h000)
        arst_n = 1'b1;
        end_sim();
    end
endmodule
